/* shared/fifo_ctrl_pkg.sv */
// Shared constants and types for the bidirectional queue control block
package fifo_ctrl_pkg;

  localparam int DATA_W = 36;
  localparam int LANES  = 4;

  // Almost-flag offsets selected at reset release
  localparam logic [6:0] OFFSET_HH = 7'h10;
  localparam logic [6:0] OFFSET_HL = 7'h0C;
  localparam logic [6:0] OFFSET_LH = 7'h08;
  localparam logic [6:0] OFFSET_LL = 7'h04;
  localparam logic [6:0] QUEUE_DEPTH = 7'h40;

  // Port B bus size codes {hi,lo}
  localparam logic [1:0] SIZE_LONG = 2'h0;
  localparam logic [1:0] SIZE_BYTE = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [1:0] SIZE_MBOX = 2'h3;

  // Swap codes {hi,lo}
  localparam logic [1:0] SWAP_NONE = 2'h0;
  localparam logic [1:0] SWAP_BYTE = 2'h1;
  localparam logic [1:0] SWAP_WORD = 2'h2;
  localparam logic [1:0] SWAP_BOTH = 2'h3;

  // APB register map
  localparam logic [11:0] ADDR_CFG    = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_MBX_AB = 12'h008;
  localparam logic [11:0] ADDR_MBX_BA = 12'h00C;

  typedef struct packed {
    logic port_b_parity_gen;
    logic port_a_parity_gen;
    logic odd_parity;
  } cfg_t;

  localparam cfg_t CFG_RESET = 3'h0;

endpackage

/* rtl/parity_lanes.sv */
// Per-byte parity check and parity generation over 9-bit lanes
`timescale 1ns/1ps
`default_nettype none
module parity_lanes #(
  parameter int LANES = 4
) (
  input  wire logic [9*LANES-1:0] data_in,
  input  wire logic               odd,
  input  wire logic               gen,
  output logic      [LANES-1:0]   byte_ok,
  output logic      [9*LANES-1:0] data_out
);

  genvar i;
  generate
    for (i = 0; i < LANES; i++) begin : g_lane
      wire [8:0] lane = data_in[9*i +: 9];
      wire       par  = (^lane[7:0]) ^ odd;
      assign byte_ok[i]          = ((^lane) == odd);
      assign data_out[9*i +: 8]  = lane[7:0];
      assign data_out[9*i + 8]   = gen ? par : lane[8];
    end
  endgenerate

endmodule
`default_nettype wire

/* rtl/byte_lanes.sv */
// Port B byte-order swap and active lane selection
`timescale 1ns/1ps
`default_nettype none
module byte_lanes
  import fifo_ctrl_pkg::*;
(
  input  wire logic [35:0] data_in,
  input  wire logic [1:0]  size,
  input  wire logic        endian,
  input  wire logic [1:0]  swap,
  output logic      [35:0] data_out,
  output logic      [3:0]  lane_mask
);

  logic [35:0] swapped;

  always_comb begin
    unique case (swap)
      SWAP_NONE: swapped = data_in;
      SWAP_BYTE: swapped = {data_in[8:0], data_in[17:9], data_in[26:18], data_in[35:27]};
      SWAP_WORD: swapped = {data_in[17:0], data_in[35:18]};
      SWAP_BOTH: swapped = {data_in[26:18], data_in[35:27], data_in[8:0], data_in[17:9]};
    endcase
  end

  // Endian low uses the upper lanes, high the lower lanes
  assign lane_mask = (size == SIZE_WORD) ? (endian ? 4'h3 : 4'hC) :
                     (size == SIZE_BYTE) ? (endian ? 4'h1 : 4'h8) : 4'hF;

  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_mask
      assign data_out[9*i +: 9] = lane_mask[i] ? swapped[9*i +: 9] : 9'h000;
    end
  endgenerate

endmodule
`default_nettype wire

/* rtl/bidir_fifo_mailbox_parity_ctrl.sv */
// Mailbox, parity, bus sizing and flag control of a bidirectional queue pair
`timescale 1ns/1ps
`default_nettype none
module bidir_fifo_mailbox_parity_ctrl
  import fifo_ctrl_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        offset_sel_lo,
  input  wire logic        offset_sel_hi,
  input  wire logic        port_a_select_n,
  input  wire logic        port_a_enable,
  input  wire logic        port_a_dir_sel,
  input  wire logic        port_a_mailbox_sel,
  input  wire logic [35:0] port_a_data_in,
  output logic      [35:0] port_a_data_out,
  output logic             port_a_data_oe,
  input  wire logic        port_b_select_n,
  input  wire logic        port_b_enable,
  input  wire logic        port_b_dir_sel,
  input  wire logic        port_b_size_sel_lo,
  input  wire logic        port_b_size_sel_hi,
  input  wire logic        endian_sel,
  input  wire logic        swap_sel_lo,
  input  wire logic        swap_sel_hi,
  input  wire logic [35:0] port_b_data_in,
  output logic      [35:0] port_b_data_out,
  output logic             port_b_data_oe,
  input  wire logic [6:0]  a_to_b_level,
  input  wire logic [6:0]  b_to_a_level,
  input  wire logic [35:0] b_to_a_head,
  input  wire logic [35:0] a_to_b_head,
  output logic             a_to_b_push,
  output logic      [35:0] a_to_b_push_data,
  output logic             b_to_a_push,
  output logic      [35:0] b_to_a_push_data,
  output logic             a_to_b_pop,
  output logic             b_to_a_pop,
  output logic             a_to_b_mail_flag,
  output logic             b_to_a_mail_flag,
  output logic             port_a_parity_err,
  output logic             port_b_parity_err,
  output logic             port_a_full_n,
  output logic             port_a_almost_full_n,
  output logic             port_a_empty_n,
  output logic             port_a_almost_empty_n,
  output logic             port_b_full_n,
  output logic             port_b_almost_full_n,
  output logic             port_b_empty_n,
  output logic             port_b_almost_empty_n
);

  // ****************************************
  // State
  // ****************************************
  cfg_t        cfg_ff;
  logic        ofs_taken_ff;
  logic [1:0]  ofs_code_ff;
  logic [6:0]  offset_ff;
  logic [1:0]  size_cap_ff;
  logic        endian_cap_ff;
  logic [1:0]  size_ff;
  logic        endian_ff;
  logic [35:0] mbx_ab_ff;
  logic [35:0] mbx_ba_ff;
  logic        flag_ab_ff;
  logic        flag_ba_ff;
  logic [35:0] out_a_ff;
  logic [35:0] out_b_ff;
  logic [35:0] dout_a_ff;
  logic [35:0] dout_b_ff;
  logic        perr_a_ff;
  logic        perr_b_ff;
  logic [7:0]  qflags_ff;
  logic [31:0] prdata_ff;
  logic        pslverr_ff;

  // ****************************************
  // Access decode
  // ****************************************
  wire       acc_a     = ~port_a_select_n & port_a_enable;
  wire       acc_b     = ~port_b_select_n & port_b_enable;
  wire       b_mbx     = (size_ff == SIZE_MBOX);
  wire       wr_mbx_ab = acc_a & port_a_dir_sel & port_a_mailbox_sel & flag_ab_ff;
  wire       rd_mbx_ba = acc_a & ~port_a_dir_sel & port_a_mailbox_sel;
  wire       wr_mbx_ba = acc_b & port_b_dir_sel & b_mbx & flag_ba_ff;
  wire       rd_mbx_ab = acc_b & ~port_b_dir_sel & b_mbx;
  wire       push_ab   = acc_a & port_a_dir_sel & ~port_a_mailbox_sel & qflags_ff[7];
  wire       pop_ba    = acc_a & ~port_a_dir_sel & ~port_a_mailbox_sel & qflags_ff[5];
  wire       push_ba   = acc_b & port_b_dir_sel & ~b_mbx & qflags_ff[3];
  wire       pop_ab    = acc_b & ~port_b_dir_sel & ~b_mbx & qflags_ff[1];
  wire [1:0] swap_pins = {swap_sel_hi, swap_sel_lo};
  wire [1:0] size_pins = {port_b_size_sel_hi, port_b_size_sel_lo};

  // ****************************************
  // Offset capture at reset release
  // ****************************************
  wire [1:0] ofs_pins = {offset_sel_hi, offset_sel_lo};
  wire [6:0] ofs_val  = (ofs_code_ff == 2'h3) ? OFFSET_HH :
                        (ofs_code_ff == 2'h2) ? OFFSET_HL :
                        (ofs_code_ff == 2'h1) ? OFFSET_LH : OFFSET_LL;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ofs_taken_ff <= 1'b0;
      ofs_code_ff  <= 2'h0;
    end else if (!ofs_taken_ff) begin
      ofs_taken_ff <= 1'b1;
      ofs_code_ff  <= ofs_pins;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) offset_ff <= OFFSET_LL;
    else          offset_ff <= ofs_val;
  end

  // ****************************************
  // Queue flags (active low)
  // ****************************************
  // Flags follow the level after this edge, so back-to-back access cannot overrun
  wire [6:0] lvl_ab  = a_to_b_level + {6'h00, push_ab} - {6'h00, pop_ab};
  wire [6:0] lvl_ba  = b_to_a_level + {6'h00, push_ba} - {6'h00, pop_ba};
  wire [6:0] free_ab = QUEUE_DEPTH - lvl_ab;
  wire [6:0] free_ba = QUEUE_DEPTH - lvl_ba;
  wire [7:0] nxt_qflags = {lvl_ab != QUEUE_DEPTH, free_ab > offset_ff,
                           lvl_ba != 7'h00, lvl_ba > offset_ff,
                           lvl_ba != QUEUE_DEPTH, free_ba > offset_ff,
                           lvl_ab != 7'h00, lvl_ab > offset_ff};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) qflags_ff <= 8'h44;
    else          qflags_ff <= ofs_taken_ff ? nxt_qflags : 8'h44;
  end

  // Bit order: A full, A afull, A empty, A aempty, B full, B afull, B empty, B aempty
  assign {port_a_full_n, port_a_almost_full_n, port_a_empty_n, port_a_almost_empty_n,
          port_b_full_n, port_b_almost_full_n, port_b_empty_n, port_b_almost_empty_n}
         = {qflags_ff[7:6], qflags_ff[5:4], qflags_ff[3:2], qflags_ff[1:0]};

  // ****************************************
  // Port B size and endian pipeline
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      size_cap_ff   <= SIZE_LONG;
      endian_cap_ff <= 1'b0;
      size_ff       <= SIZE_LONG;
      endian_ff     <= 1'b0;
    end else begin
      size_cap_ff   <= size_pins;
      endian_cap_ff <= endian_sel;
      size_ff       <= size_cap_ff;
      endian_ff     <= endian_cap_ff;
    end
  end

  // ****************************************
  // Mailboxes and mail flags
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mbx_ab_ff  <= 36'h000000000;
      mbx_ba_ff  <= 36'h000000000;
      flag_ab_ff <= 1'b1;
      flag_ba_ff <= 1'b1;
    end else begin
      if (wr_mbx_ab) mbx_ab_ff <= port_a_data_in;
      if (wr_mbx_ba) mbx_ba_ff <= port_b_data_in;
      flag_ab_ff <= wr_mbx_ab ? 1'b0 : (rd_mbx_ab ? 1'b1 : flag_ab_ff);
      flag_ba_ff <= wr_mbx_ba ? 1'b0 : (rd_mbx_ba ? 1'b1 : flag_ba_ff);
    end
  end

  assign a_to_b_mail_flag = flag_ab_ff;
  assign b_to_a_mail_flag = flag_ba_ff;

  // ****************************************
  // Lane handling and parity
  // ****************************************
  logic [35:0] b_in_lanes;
  logic [35:0] b_out_lanes;
  logic [3:0]  b_mask;
  logic [3:0]  ok_a;
  logic [3:0]  ok_b;
  logic [35:0] gen_a;
  logic [35:0] gen_b;

  byte_lanes u_lanes_in (
    .data_in   (port_b_data_in),
    .size      (size_ff),
    .endian    (endian_ff),
    .swap      (swap_pins),
    .data_out  (b_in_lanes),
    .lane_mask (b_mask)
  );

  byte_lanes u_lanes_out (
    .data_in   (out_b_ff),
    .size      (size_ff),
    .endian    (endian_ff),
    .swap      (swap_pins),
    .data_out  (b_out_lanes),
    .lane_mask ()
  );

  wire [35:0] a_src = port_a_mailbox_sel ? mbx_ba_ff : out_a_ff;
  wire [35:0] b_src = b_mbx ? mbx_ab_ff : b_out_lanes;

  parity_lanes #(.LANES(LANES)) u_chk_a (
    .data_in  (port_a_data_in),
    .odd      (cfg_ff.odd_parity),
    .gen      (1'b0),
    .byte_ok  (ok_a),
    .data_out ()
  );

  parity_lanes #(.LANES(LANES)) u_chk_b (
    .data_in  (port_b_data_in),
    .odd      (cfg_ff.odd_parity),
    .gen      (1'b0),
    .byte_ok  (ok_b),
    .data_out ()
  );

  parity_lanes #(.LANES(LANES)) u_gen_a (
    .data_in  (a_src),
    .odd      (cfg_ff.odd_parity),
    .gen      (cfg_ff.port_a_parity_gen),
    .byte_ok  (),
    .data_out (gen_a)
  );

  parity_lanes #(.LANES(LANES)) u_gen_b (
    .data_in  (b_src),
    .odd      (cfg_ff.odd_parity),
    .gen      (cfg_ff.port_b_parity_gen),
    .byte_ok  (),
    .data_out (gen_b)
  );

  wire force_a = ~port_a_dir_sel & port_a_mailbox_sel & cfg_ff.port_a_parity_gen;
  wire force_b = ~port_b_dir_sel & b_mbx & cfg_ff.port_b_parity_gen;
  wire nxt_perr_a = force_a | (&ok_a);
  wire nxt_perr_b = force_b | (&(ok_b | ~b_mask));

  // ****************************************
  // Data registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_a_ff  <= 36'h000000000;
      out_b_ff  <= 36'h000000000;
      dout_a_ff <= 36'h000000000;
      dout_b_ff <= 36'h000000000;
      perr_a_ff <= 1'b1;
      perr_b_ff <= 1'b1;
    end else begin
      if (pop_ba) out_a_ff <= b_to_a_head;
      if (pop_ab) out_b_ff <= a_to_b_head;
      dout_a_ff <= gen_a;
      dout_b_ff <= gen_b;
      perr_a_ff <= nxt_perr_a;
      perr_b_ff <= nxt_perr_b;
    end
  end

  assign port_a_data_out   = dout_a_ff;
  assign port_b_data_out   = dout_b_ff;
  assign port_a_data_oe    = ~port_a_select_n & ~port_a_dir_sel;
  assign port_b_data_oe    = ~port_b_select_n & ~port_b_dir_sel;
  assign port_a_parity_err = perr_a_ff;
  assign port_b_parity_err = perr_b_ff;
  assign a_to_b_push       = push_ab;
  assign a_to_b_push_data  = port_a_data_in;
  assign b_to_a_push       = push_ba;
  assign b_to_a_push_data  = b_in_lanes;
  assign a_to_b_pop        = pop_ab;
  assign b_to_a_pop        = pop_ba;

  // ****************************************
  // APB slave
  // ****************************************
  wire setup   = psel & ~penable;
  wire cfg_wr  = psel & penable & pwrite & (paddr == ADDR_CFG);
  wire hit     = (paddr == ADDR_CFG) | (paddr == ADDR_STATUS) |
                 (paddr == ADDR_MBX_AB) | (paddr == ADDR_MBX_BA);
  wire [31:0] status_word = {13'h0000, offset_ff, qflags_ff, perr_b_ff, perr_a_ff,
                             flag_ba_ff, flag_ab_ff};
  wire [31:0] nxt_prdata = (paddr == ADDR_CFG)    ? {29'h00000000, cfg_ff} :
                           (paddr == ADDR_STATUS) ? status_word :
                           (paddr == ADDR_MBX_AB) ? mbx_ab_ff[31:0] :
                           (paddr == ADDR_MBX_BA) ? mbx_ba_ff[31:0] : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_ff     <= CFG_RESET;
      prdata_ff  <= 32'h00000000;
      pslverr_ff <= 1'b0;
    end else begin
      if (cfg_wr) cfg_ff <= pwdata[2:0];
      if (setup) begin
        prdata_ff  <= pwrite ? 32'h00000000 : nxt_prdata;
        pslverr_ff <= ~hit | (pwrite & (paddr != ADDR_CFG));
      end
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = 1'b1;
  assign pslverr = pslverr_ff & psel & penable;

  // ****************************************
  // Assertions
  // ****************************************
  property p_offset_map;
    @(posedge pclk) disable iff (!presetn)
      $rose(ofs_taken_ff) |=> (offset_ff == ((ofs_code_ff == 2'h3) ? 7'h10 : (ofs_code_ff == 2'h0) ? 7'h04 :
                               (ofs_code_ff == 2'h2) ? 7'h0C : 7'h08));
  endproperty
  a_offset_map: assert property (p_offset_map) else $error("offset value mismatch");

  property p_mail_ab_write;
    @(posedge pclk) disable iff (!presetn)
      (acc_a && port_a_dir_sel && port_a_mailbox_sel && a_to_b_mail_flag)
        |=> (!a_to_b_mail_flag && mbx_ab_ff == $past(port_a_data_in));
  endproperty
  a_mail_ab_write: assert property (p_mail_ab_write) else $error("A mailbox write lost");

  property p_mail_ab_lock;
    @(posedge pclk) disable iff (!presetn)
      (!a_to_b_mail_flag && !rd_mbx_ab) |=> $stable(mbx_ab_ff) && !a_to_b_mail_flag;
  endproperty
  a_mail_ab_lock: assert property (p_mail_ab_lock) else $error("A mailbox changed while full");

  property p_mail_ab_read;
    @(posedge pclk) disable iff (!presetn)
      (acc_b && !port_b_dir_sel && size_ff == 2'h3 &&
       !(acc_a && port_a_dir_sel && port_a_mailbox_sel && a_to_b_mail_flag))
        |=> a_to_b_mail_flag;
  endproperty
  a_mail_ab_read: assert property (p_mail_ab_read) else $error("A mail flag not set by read");

  property p_mail_ba_write;
    @(posedge pclk) disable iff (!presetn)
      (acc_b && port_b_dir_sel && size_ff == 2'h3 && b_to_a_mail_flag)
        |=> (!b_to_a_mail_flag && mbx_ba_ff == $past(port_b_data_in));
  endproperty
  a_mail_ba_write: assert property (p_mail_ba_write) else $error("B mailbox write lost");

  property p_mail_ba_read;
    @(posedge pclk) disable iff (!presetn)
      (acc_a && !port_a_dir_sel && port_a_mailbox_sel && !(acc_b && port_b_dir_sel && size_ff == 2'h3))
        |=> b_to_a_mail_flag;
  endproperty
  a_mail_ba_read: assert property (p_mail_ba_read) else $error("B mail flag not set by read");

  property p_force_a;
    @(posedge pclk) disable iff (!presetn)
      (!port_a_dir_sel && port_a_mailbox_sel && cfg_ff.port_a_parity_gen) |=> port_a_parity_err;
  endproperty
  a_force_a: assert property (p_force_a) else $error("port A parity flag not forced");

  property p_force_b;
    @(posedge pclk) disable iff (!presetn)
      (!port_b_dir_sel && size_ff == 2'h3 && cfg_ff.port_b_parity_gen) |=> port_b_parity_err;
  endproperty
  a_force_b: assert property (p_force_b) else $error("port B parity flag not forced");

  property p_size_lag;
    @(posedge pclk) disable iff (!presetn)
      1'b1 |=> ##1 (size_ff == $past(size_pins, 2));
  endproperty
  a_size_lag: assert property (p_size_lag) else $error("bus size not applied two edges late");

  c_mail_ab_trip: cover property (@(posedge pclk) disable iff (!presetn) wr_mbx_ab ##[1:20] rd_mbx_ab);
  c_mail_ba_trip: cover property (@(posedge pclk) disable iff (!presetn) wr_mbx_ba ##[1:20] rd_mbx_ba);
  c_perr_b: cover property (@(posedge pclk) disable iff (!presetn) !port_b_parity_err);

endmodule
`default_nettype wire

/* test/queue_model.sv */
// Behavioural model of one external queue behind the control block
`timescale 1ns/1ps
`default_nettype none
module queue_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        push,
  input  wire logic [35:0] push_data,
  input  wire logic        pop,
  output logic      [6:0]  level,
  output logic      [35:0] head
);
  logic [35:0] mem_ff [64];
  logic [5:0]  wr_ff;
  logic [5:0]  rd_ff;
  logic [6:0]  level_ff;
  // Empty queue shows no stale word
  assign head  = (level_ff == 7'h00) ? ~mem_ff[rd_ff] : mem_ff[rd_ff];
  assign level = level_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ff    <= 6'h00;
      rd_ff    <= 6'h00;
      level_ff <= 7'h00;
    end else begin
      if (push) begin
        mem_ff[wr_ff] <= push_data;
      end
      wr_ff    <= wr_ff + {5'h00, push};
      rd_ff    <= rd_ff + {5'h00, pop};
      level_ff <= level_ff + {6'h00, push} - {6'h00, pop};
    end
  end
endmodule
`default_nettype wire

/* test/testbench.sv */
// Self-checking bench for the queue control block
`timescale 1ns/1ps
`default_nettype none
module testbench import fifo_ctrl_pkg::*;;
  localparam logic [35:0] W1 = 36'h1_2345_6789;
  localparam logic [35:0] W3 = 36'hA_BCDE_F012;
  localparam logic [35:0] W5 = 36'h9_8765_4321;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, offset_sel_lo = 1'b0, offset_sel_hi = 1'b0;
  logic        endian_sel = 1'b0, swap_sel_lo = 1'b0, swap_sel_hi = 1'b0;
  logic        port_a_select_n = 1'b1, port_a_enable = 1'b0, port_a_dir_sel = 1'b0, port_a_mailbox_sel = 1'b0;
  logic        port_b_select_n = 1'b1, port_b_enable = 1'b0, port_b_dir_sel = 1'b0;
  logic        port_b_size_sel_lo = 1'b0, port_b_size_sel_hi = 1'b0;
  logic [35:0] port_a_data_in = 36'h0, port_b_data_in = 36'h0, port_a_data_out, port_b_data_out;
  logic        port_a_data_oe, port_b_data_oe, a_to_b_push, b_to_a_push, a_to_b_pop, b_to_a_pop;
  logic [35:0] a_to_b_push_data, b_to_a_push_data, a_to_b_head, b_to_a_head;
  logic [6:0]  a_to_b_level, b_to_a_level;
  logic        a_to_b_mail_flag, b_to_a_mail_flag, port_a_parity_err, port_b_parity_err;
  logic        port_a_full_n, port_a_almost_full_n, port_a_empty_n, port_a_almost_empty_n;
  logic        port_b_full_n, port_b_almost_full_n, port_b_empty_n, port_b_almost_empty_n;
  int          n_errors = 0, n_compared = 0, cyc = 0;
  wire   [7:0] rflags = {a_to_b_mail_flag, b_to_a_mail_flag, port_a_almost_full_n, port_b_almost_full_n,
                         port_a_empty_n, port_a_almost_empty_n, port_a_full_n, port_b_full_n};
  bidir_fifo_mailbox_parity_ctrl i_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .offset_sel_lo, .offset_sel_hi, .port_a_select_n, .port_a_enable, .port_a_dir_sel, .port_a_mailbox_sel,
    .port_a_data_in, .port_a_data_out, .port_a_data_oe, .port_b_select_n, .port_b_enable, .port_b_dir_sel,
    .port_b_size_sel_lo, .port_b_size_sel_hi, .endian_sel, .swap_sel_lo, .swap_sel_hi, .port_b_data_in,
    .port_b_data_out, .port_b_data_oe, .a_to_b_level, .b_to_a_level, .b_to_a_head, .a_to_b_head,
    .a_to_b_push, .a_to_b_push_data, .b_to_a_push, .b_to_a_push_data, .a_to_b_pop, .b_to_a_pop,
    .a_to_b_mail_flag, .b_to_a_mail_flag, .port_a_parity_err, .port_b_parity_err, .port_a_full_n,
    .port_a_almost_full_n, .port_a_empty_n, .port_a_almost_empty_n, .port_b_full_n, .port_b_almost_full_n,
    .port_b_empty_n, .port_b_almost_empty_n
  );
  queue_model i_ab (.pclk, .presetn, .push(a_to_b_push), .push_data(a_to_b_push_data), .pop(a_to_b_pop),
                    .level(a_to_b_level), .head(a_to_b_head));
  queue_model i_ba (.pclk, .presetn, .push(b_to_a_push), .push_data(b_to_a_push_data), .pop(b_to_a_pop),
                    .level(b_to_a_level), .head(b_to_a_head));
  always #20 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      results();
    end
  end
  function automatic logic [35:0] gen(input logic [35:0] w, input logic odd);
    logic [35:0] r;
    r = w;
    for (int i = 0; i < 4; i++) r[9*i+8] = ^w[9*i +: 8] ^ odd;
    return r;
  endfunction
  task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic a_op(input logic dir, input logic mbx, input logic [35:0] d);
    @(posedge pclk);
    port_a_select_n <= 1'b0;
    port_a_enable <= 1'b1;
    port_a_dir_sel <= dir;
    port_a_mailbox_sel <= mbx;
    port_a_data_in <= d;
    #1 chk("a_oe", !dir, port_a_data_oe);
    @(posedge pclk);
    port_a_select_n <= 1'b1;
    port_a_enable <= 1'b0;
    #1;
  endtask
  task automatic b_op(input logic dir, input logic [35:0] d);
    @(posedge pclk);
    port_b_select_n <= 1'b0;
    port_b_enable <= 1'b1;
    port_b_dir_sel <= dir;
    port_b_data_in <= d;
    #1 chk("b_oe", !dir, port_b_data_oe);
    @(posedge pclk);
    port_b_select_n <= 1'b1;
    port_b_enable <= 1'b0;
    #1;
  endtask
  task automatic rst(input logic [1:0] code);
    @(posedge pclk);
    presetn <= 1'b0;
    {offset_sel_hi, offset_sel_lo} <= code;
    tick(4);
    chk("rst_flags", 8'hF0, rflags);
    @(posedge pclk);
    presetn <= 1'b1;
    tick(2);
  endtask
  task automatic results();
    $display("Comparisons %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    for (int c = 0; c < 4; c++) begin
      rst(c[1:0]);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk("offset", 4 * (c + 1), rd[18:12]);
    end
    apb(1'b0, ADDR_CFG, 32'h0);
    chk("cfg_rst", CFG_RESET, rd);
    apb(1'b1, ADDR_CFG, 32'h5);
    apb(1'b0, ADDR_CFG, 32'h0);
    chk("cfg", 32'h5, rd);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped", 33'h1_0000_0000, {err, rd});
    apb(1'b1, ADDR_STATUS, 32'h0);
    chk("ro_write", 1'b1, err);
    apb(1'b1, ADDR_CFG, 32'h0);
    a_op(1'b1, 1'b1, W1);
    chk("ab_flag", 1'b0, a_to_b_mail_flag);
    a_op(1'b1, 1'b1, 36'h0_5555_5555);
    apb(1'b0, ADDR_MBX_AB, 32'h0);
    chk("ab_mbx", W1[31:0], rd);
    @(posedge pclk);
    {port_b_size_sel_hi, port_b_size_sel_lo} <= SIZE_MBOX;
    tick(2);
    b_op(1'b0, 36'h0);
    chk("ab_flag", 1'b1, a_to_b_mail_flag);
    tick(1);
    chk("b_out", W1, port_b_data_out);
    apb(1'b1, ADDR_CFG, 32'h5);
    tick(2);
    chk("b_perr_force", 1'b1, port_b_parity_err);
    chk("b_gen", gen(W1, 1'b1), port_b_data_out);
    b_op(1'b1, W3);
    chk("ba_flag", 1'b0, b_to_a_mail_flag);
    b_op(1'b1, 36'h0_AAAA_AAAA);
    apb(1'b1, ADDR_CFG, 32'h3);
    @(posedge pclk);
    port_a_select_n <= 1'b0;
    port_a_dir_sel <= 1'b0;
    port_a_mailbox_sel <= 1'b1;
    port_a_data_in <= 36'h0;
    tick(3);
    chk("a_perr", 1'b1, port_a_parity_err);
    chk("a_out", gen(W3, 1'b1), port_a_data_out);
    a_op(1'b0, 1'b1, 36'h0);
    chk("ba_flag", 1'b1, b_to_a_mail_flag);
    apb(1'b1, ADDR_CFG, 32'h1);
    for (int i = 0; i < 5; i++) begin
      @(posedge pclk);
      port_a_mailbox_sel <= 1'b0;
      port_a_data_in <= gen(W5, 1'b1) ^ (36'h1 << 9 * i);
      tick(2);
      chk("a_perr", i == 4, port_a_parity_err);
    end
    apb(1'b1, ADDR_CFG, 32'h0);
    tick(2);
    chk("a_perr_even", 1'b0, port_a_parity_err);
    apb(1'b1, ADDR_CFG, 32'h1);
    @(posedge pclk);
    {port_b_size_sel_hi, port_b_size_sel_lo} <= SIZE_BYTE;
    port_b_data_in <= gen(36'h0_0000_00A5, 1'b1) ^ 36'h1;
    tick(3);
    chk("b_perr", 1'b1, port_b_parity_err);
    @(posedge pclk);
    port_b_data_in <= gen(36'h0, 1'b1) ^ 36'h1 << 27;
    tick(2);
    chk("b_perr", 1'b0, port_b_parity_err);
    apb(1'b1, ADDR_CFG, 32'h0);
    @(posedge pclk);
    {port_b_size_sel_hi, port_b_size_sel_lo} <= SIZE_LONG;
    {swap_sel_hi, swap_sel_lo} <= SWAP_BYTE;
    a_op(1'b1, 1'b0, W5);
    tick(4);
    b_op(1'b0, 36'h0);
    tick(1);
    chk("b_pop", {W5[8:0], W5[17:9], W5[26:18], W5[35:27]}, port_b_data_out);
    results();
  end
endmodule
`default_nettype wire
